// ==== logic/acs_conv_if.sv ====
// Purpose: carries conversion requests between sequencer and conversion timer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse, done and abort are one-cycle pulses
interface acs_conv_if;
  logic start;   // begin counting conversion clock periods
  logic done;    // full conversion completed
  logic abort;   // conversion cut short
  logic busy;    // conversion in progress
  modport seq (output start, input done, input abort, input busy);
  modport tmr (input start, output done, output abort, output busy);
endinterface : acs_conv_if

// ==== logic/acs_conv_timer.sv ====
// Purpose: counts full conversion clock periods for one conversion
// Assumes: conversion clock sampled synchronously to i_sys_clk
// Notes:   a new start before the count completes aborts the conversion
module acs_conv_timer
(
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  // conversion clock level
  input  wire logic i_conv_clk,
  // link to sequencer
  acs_conv_if.tmr   conv
);
  typedef struct packed {
    logic       busy;
    logic       clk_d;
    logic [3:0] periods;
    logic       done;
    logic       abort;
  } acs_tmr_t;
  acs_tmr_t st;
  acs_tmr_t next_st;

  // period counting: a period is counted on each rising edge after start
  always_comb
  begin
    next_st       = st;
    next_st.clk_d = i_conv_clk;
    next_st.done  = 1'b0;
    next_st.abort = 1'b0;
    if (conv.start)
    begin
      // restart cuts a conversion that has not seen all its periods
      next_st.abort   = st.busy;
      next_st.busy    = 1'b1;
      next_st.periods = 4'h0;
    end
    else if (st.busy && i_conv_clk && !st.clk_d)
    begin
      // the first rise after start only opens a whole period, because
      // start may fall anywhere inside a period; so the conversion ends on
      // the rise that closes the thirteenth whole period, never on 12.5
      if (st.periods == acs_pkg::CONV_PERIODS)
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
      next_st.periods = st.periods + 4'h1;
    end
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign conv.done  = st.done;
  assign conv.abort = st.abort;
  assign conv.busy  = st.busy;
endmodule // acs_conv_timer

// ==== logic/acs_pkg.sv ====
// Purpose: shared constants and types for the converter channel sequencer
// Assumes: 12-bit parallel host word, eight analog inputs
// Notes:   field positions of the control word and mode encodings
package acs_pkg;
  // control word field positions
  localparam int ADDR_HI       = 7;
  localparam int ADDR_LO       = 5;
  localparam int TYPE_HI       = 4;
  localparam int TYPE_LO       = 3;
  localparam int SHADOW_SELECT_BIT_SEL_POS  = 2;
  localparam int SEQ_EN_POS    = 1;
  localparam int DATA_W        = 12;
  localparam int CHAN_N        = 8;
  // conversion clock periods needed per conversion
  localparam logic [3:0] CONV_PERIODS = 4'hd;
  // input type encodings
  typedef enum logic [1:0] {
    ACS_SINGLE = 2'h0,
    ACS_FULL   = 2'h1,
    ACS_PSEUDO1 = 2'h2,
    ACS_PSEUDO7 = 2'h3
  } acs_type_t;
  // sequencer modes, coded {sequence_enable_bit, shadow_select_bit}
  localparam logic [1:0] SQ_NONE  = 2'h0;
  localparam logic [1:0] SQ_SHADOW_SELECT_BIT  = 2'h1;
  localparam logic [1:0] SQ_KEEP  = 2'h2;
  localparam logic [1:0] SQ_CONSEC = 2'h3;
  // reset values
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [2:0] ADDR_RST    = 3'h0;
endpackage : acs_pkg

// ==== logic/acs_sequencer.sv ====
// Purpose: channel selection and sequencer for an eight-input converter
// Assumes: host bus, strobe and start pins are synchronous to i_sys_clk
// Notes:   writes commit on the rising edge of the write strobe
// Function
// - input type decode; single-ended uses ground
// - full differential pairs even/odd partner negative
// - pseudo mode one pairs like differential
// - pseudo seven uses input seven negative
// - conversion needs thirteen full clock periods
// - enables captured from low byte on strobe rise
// - enables written only after shadow-select write
// - enable bit n gates channel n
// - ascending from lowest enabled, cycling on start
// - sequence runs until non-keep control write
// - pair sequences skip swapped polarity
// - no sequencer converts last written address
// - keep write updates fields, sequence continues
// - consecutive mode runs zero to address
// - address field in bits seven to five
// - shadow select bit two, sequence bit one
// - input type field in bits four, three
module acs_sequencer
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  // host parallel port
  input  wire logic [11:0] i_data_bus,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_conversion_start_n,
  // conversion clock
  input  wire logic        i_conversion_clock_in,
  // selection to analog front end
  output logic [2:0]       o_pos_input,
  output logic [2:0]       o_neg_input,
  output logic             o_neg_is_ground,
  output logic [1:0]       o_input_type,
  output logic [2:0]       o_channel,
  // conversion status
  output logic             o_conv_busy,
  output logic             o_conv_done,
  output logic             o_conv_abort,
  // control bits beyond this block
  output logic [11:0]      o_control
);
  // whole module state
  typedef struct packed {
    logic [11:0] ctrl;        // last control word
    logic [7:0]  enables;     // sequence_channel_enables, write-only
    logic        shadow_select_bit_next;   // next write goes to enables
    logic        wr_d;        // delayed strobe for edge detect
    logic        cs_d;        // delayed start for edge detect
    logic        seq_run;     // shadow sequence active
    logic        consec_run;  // consecutive sequence active
    logic [2:0]  cur;         // channel of the current conversion
    logic [2:0]  nxt;         // channel of the next conversion
    logic [2:0]  pos;         // routed positive input
    logic [2:0]  neg;         // routed negative input
    logic        gnd;         // negative is analog ground
  } acs_seq_t;
  acs_seq_t st;
  acs_seq_t next_st;

  // link to the conversion period timer
  acs_conv_if conv ();

  // find next enabled channel strictly above cur, or from channel 0 when first, wrapping; pairs step by 2
  // the scan visits every bit once, so an empty set leaves r at cur;
  // the enables write catches that case before it matters
  function automatic logic [2:0] next_enabled(input logic [7:0] en, input logic [2:0] cur,
                                               input logic pairs, input logic first);
    logic [2:0] c;
    logic [2:0] r;
    logic       hit;
    r   = cur;
    hit = 1'b0;
    for (int k = 1; k <= 8; k++)
    begin
      c = 3'(int'(cur) + k);
      if (first)
        c = 3'(k - 1);
      // limitation: only the even bit of a pair is looked at, so a host
      // that sets just the odd bit gets no conversion of that pair
      // pair sequences take only the even member of a pair
      if (!hit && en[c] && !(pairs && c[0]))
      begin
        r   = c;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // route a channel address to its positive and negative inputs
  // packed as {positive, negative, negative is ground}; in single-ended
  // mode the negative index repeats the positive one and is unused
  function automatic logic [6:0] route(input logic [1:0] ty, input logic [2:0] a);
    logic [6:0] r;
    r = {a, a, 1'b1};
    case (ty)
      acs_pkg::ACS_FULL:   r = {a, a ^ 3'h1, 1'b0};
      acs_pkg::ACS_PSEUDO1: r = {a, a ^ 3'h1, 1'b0};
      acs_pkg::ACS_PSEUDO7: r = {a, 3'h7, 1'b0};
      default:             r = {a, a, 1'b1};
    endcase
    return r;
  endfunction

  // edge detects and decoded fields shared by the processes below
  logic       wr_rise;
  logic       cs_fall;
  logic [1:0] sq_mode;
  logic [1:0] ty;
  logic       pairs;
  logic [6:0] rt;
  // a write commits on the strobe's rising edge, data still valid then
  assign wr_rise = i_write_strobe_n && !st.wr_d;
  // the sample instant is the falling edge of the start pin
  assign cs_fall = !i_conversion_start_n && st.cs_d;
  assign sq_mode = {i_data_bus[acs_pkg::SEQ_EN_POS], i_data_bus[acs_pkg::SHADOW_SELECT_BIT_SEL_POS]};
  assign ty      = st.ctrl[acs_pkg::TYPE_HI:acs_pkg::TYPE_LO];
  assign pairs   = (ty == acs_pkg::ACS_FULL) || (ty == acs_pkg::ACS_PSEUDO1);
  // a start that collides with a write is dropped whole, timer included,
  // so channel and timer never disagree about which conversion runs
  assign conv.start = cs_fall && !wr_rise;
  assign rt      = route(ty, st.cur);

  // host writes and sequencing
  always_comb
  begin
    next_st      = st;
    next_st.wr_d = i_write_strobe_n;
    next_st.cs_d = i_conversion_start_n;
    // route outputs trail the channel by one cycle; that keeps the
    // decode out of the path from the start pin
    next_st.pos  = rt[6:4];
    next_st.neg  = rt[3:1];
    next_st.gnd  = rt[0];
    if (wr_rise)
    begin
      if (st.shadow_select_bit_next)
      begin
        // enables load and start the shadow sequence from its lowest channel
        next_st.enables   = i_data_bus[7:0];
        next_st.shadow_select_bit_next = 1'b0;
        next_st.seq_run   = 1'b1;
        next_st.consec_run = 1'b0;
        next_st.nxt = next_enabled(i_data_bus[7:0], 3'h0, pairs, 1'b1);
        if (i_data_bus[7:0] == acs_pkg::ENABLES_RST)
        begin
          next_st.seq_run = 1'b0;
          next_st.nxt     = st.ctrl[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO];
        end
      end
      else
      begin
        next_st.ctrl      = i_data_bus;
        next_st.shadow_select_bit_next = (sq_mode == acs_pkg::SQ_SHADOW_SELECT_BIT);
        // a keep write (1, 0) leaves the sequence position untouched
        if (sq_mode != acs_pkg::SQ_KEEP)
        begin
          next_st.seq_run    = 1'b0;
          next_st.consec_run = (sq_mode == acs_pkg::SQ_CONSEC);
          // no sequencer or consecutive start: address or channel zero
          next_st.nxt = (sq_mode == acs_pkg::SQ_CONSEC) ? 3'h0 :
                        i_data_bus[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO];
        end
      end
    end
    else if (cs_fall)
    begin
      // sample channel is latched at the start falling edge
      next_st.cur = st.nxt;
      // shadow sequences scan the enables, consecutive ones count up
      if (st.seq_run)
        next_st.nxt = next_enabled(st.enables, st.nxt, pairs, 1'b0);
      else if (st.consec_run)
        next_st.nxt = (st.nxt >= st.ctrl[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO]) ? 3'h0 :
                      st.nxt + 3'h1;
    end
  end

  // state register; strobe and start idle high
  // edge detectors reset to the idle level of their pins, so release
  // of reset never looks like a strobe, and looks like a start only if the start pin is already low
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st      <= '0;
      st.wr_d <= 1'b1;
      st.cs_d <= 1'b1;
      st.gnd  <= 1'b1;
    end
    else
      st <= next_st;
  end

  // conversion period timer
  // the timer owns busy, done and abort; this module only starts it
  acs_conv_timer u_timer
  (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_conv_clk (i_conversion_clock_in),
    .conv       (conv.tmr)
  );

  // outputs straight from the state register or the timer
  assign o_pos_input     = st.pos;
  assign o_neg_input     = st.neg;
  assign o_neg_is_ground = st.gnd;
  assign o_input_type    = ty;
  assign o_channel       = st.cur;
  assign o_control       = st.ctrl;
  assign o_conv_busy     = conv.busy;
  assign o_conv_done     = conv.done;
  assign o_conv_abort    = conv.abort;
endmodule // acs_sequencer

// ==== verif/acs_host_model.sv ====
// Purpose: host model for the parallel port and conversion clock
// Assumes: pins move 1 ns after the rising edge
// Notes:   released bus shows the inverse of the last word
module acs_host_model
(
  // clock
  input  wire logic   i_clk,
  // host pins
  output logic [11:0] o_db,
  output logic        o_wr_n,
  output logic        o_start_n,
  output logic        o_cclk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div = 2'h0; // clock divider
  initial
  begin
    o_db = 12'h000;
    o_wr_n = 1'b1;
    o_start_n = 1'b1;
    o_cclk = 1'b0;
  end
  // free running, four system cycles a period
  always @(posedge i_clk)
  begin
    #1 div = div + 2'h1;
    o_cclk = div[1];
  end
  // strobe low two cycles, data held past the rise
  task automatic write(input logic [11:0] d);
    @(posedge i_clk) #1 o_db = d;
    o_wr_n = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 o_wr_n = 1'b1;
    @(posedge i_clk) #1 o_db = ~d;
  endtask
  // pulse kept clear of a clock rise, always ends high
  task automatic pulse();
    @(posedge o_cclk);
    repeat (2) @(posedge i_clk);
    #1 o_start_n = 1'b0;
    @(posedge i_clk) #1 o_start_n = 1'b1;
  endtask
endmodule // acs_host_model

// ==== verif/acs_props.sv ====
// Purpose: port checks for acs_sequencer
// Assumes: one clock domain
// Notes:   helper flops mirror write and start detection
module acs_props
(
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_rstn,
  // host pins
  input wire logic [11:0] i_data_bus,
  input wire logic        i_write_strobe_n,
  input wire logic        i_conversion_start_n,
  input wire logic        i_conversion_clock_in,
  // outputs
  input wire logic [2:0]  o_pos_input,
  input wire logic [2:0]  o_neg_input,
  input wire logic        o_neg_is_ground,
  input wire logic [1:0]  o_input_type,
  input wire logic [2:0]  o_channel,
  input wire logic        o_conv_busy,
  input wire logic        o_conv_done,
  input wire logic        o_conv_abort,
  input wire logic [11:0] o_control
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       wr_q, st_q, ck_q, steer; // last levels, next write to enables
  logic [4:0] rises;                   // clock rises since start
  wire        wr = i_write_strobe_n && !wr_q;
  wire        st = !i_conversion_start_n && st_q && !wr; // start loses to write
  // track levels, steering and counted rises
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_q  <= 1'b1;
      st_q  <= 1'b1;
      ck_q  <= 1'b0;
      steer <= 1'b0;
      rises <= 5'h00;
    end
    else
    begin
      wr_q  <= i_write_strobe_n;
      st_q  <= i_conversion_start_n;
      ck_q  <= i_conversion_clock_in;
      if (wr)
        steer <= !steer && i_data_bus[2:1] == 2'h2;
      if (st)
        rises <= 5'h00;
      else if (i_conversion_clock_in && !ck_q && rises != 5'h1f)
        rises <= rises + 5'h01;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // route outputs settle two cycles after a start
  sequence s_route;
    st ##2 1'b1;
  endsequence
  a_ctrl_write: assert property (wr && !steer |=> o_control == $past(i_data_bus))
    else $error("control word not taken");
  a_shadow_keep: assert property (wr && steer |=> $stable(o_control))
    else $error("enables write touched control");
  a_single_gnd: assert property (s_route ##0 o_input_type == acs_pkg::ACS_SINGLE
    |-> o_neg_is_ground && o_pos_input == o_channel)
    else $error("single-ended route wrong");
  a_pair_neg: assert property (s_route ##0 o_input_type inside {acs_pkg::ACS_FULL,
    acs_pkg::ACS_PSEUDO1} |-> !o_neg_is_ground && o_pos_input == o_channel
    && o_neg_input == (o_pos_input ^ 3'h1))
    else $error("pair route wrong");
  a_common_neg: assert property (s_route ##0 o_input_type == acs_pkg::ACS_PSEUDO7
    |-> !o_neg_is_ground && o_neg_input == 3'h7 && o_pos_input == o_channel)
    else $error("common negative route wrong");
  // the first rise after start opens the first whole period
  a_done_count: assert property (o_conv_done |-> rises == 5'h0e)
    else $error("done not after thirteen periods");
  a_done_ends: assert property (o_conv_done |-> !o_conv_busy)
    else $error("busy after done");
  a_abort_start: assert property (st && o_conv_busy |-> ##[1:2] o_conv_abort)
    else $error("restart did not abort");
  a_chan_hold: assert property ($changed(o_channel) |-> $past(st || wr))
    else $error("channel moved without cause");
  a_ctrl_hold: assert property ($changed(o_control) |-> $past(wr))
    else $error("control moved without write");
endmodule // acs_props
bind acs_sequencer acs_props acs_props_inst (.i_sys_clk, .i_rstn, .i_data_bus,
  .i_write_strobe_n, .i_conversion_start_n, .i_conversion_clock_in, .o_pos_input,
  .o_neg_input, .o_neg_is_ground, .o_input_type, .o_channel, .o_conv_busy,
  .o_conv_done, .o_conv_abort, .o_control);

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the channel sequencer
// Assumes: host model drives every host pin; the bench drives clock and reset
// Notes:   expectations come from bench functions only
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_sys_clk = 1'b0; // 25 MHz
  logic        i_rstn = 1'b0;
  logic [11:0] db, ctl, ctl_q;
  logic        wr_n, st_n, cclk, gnd, busy, done, abrt;
  logic [2:0]  pos, neg, ch, cur, a;
  logic [1:0]  ty, o_type;
  logic [7:0]  en;
  logic [31:0] rnd = 32'h216a3b4f;
  int          fails = 0, cmp_count = 0, k, j;
  always #20 i_sys_clk = ~i_sys_clk;
  acs_host_model acs_host_model_inst (.i_clk(i_sys_clk), .o_db(db), .o_wr_n(wr_n),
    .o_start_n(st_n), .o_cclk(cclk));
  acs_sequencer acs_sequencer_inst (.i_sys_clk, .i_rstn, .i_data_bus(db),
    .i_write_strobe_n(wr_n), .i_conversion_start_n(st_n), .i_conversion_clock_in(cclk),
    .o_pos_input(pos), .o_neg_input(neg), .o_neg_is_ground(gnd), .o_input_type(o_type),
    .o_channel(ch), .o_conv_busy(busy), .o_conv_done(done), .o_conv_abort(abrt),
    .o_control(ctl_q));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // ground flag and negative input
  function automatic logic [3:0] exp_neg(input logic [1:0] t, input logic [2:0] p);
    if (t == acs_pkg::ACS_SINGLE) return {1'b1, p};
    if (t == acs_pkg::ACS_PSEUDO7) return 4'h7;
    return {1'b0, p ^ 3'h1};
  endfunction
  // next enabled channel, wrapping; pairs on even bits
  function automatic logic [2:0] exp_next(input logic [7:0] e, input logic [2:0] c,
      input logic f, input logic pr, input logic [2:0] ad);
    logic [7:0] m;
    logic [2:0] s;
    m = pr ? (e & (e >> 1) & 8'h55) : e;
    s = f ? 3'h0 : c + 3'h1;
    for (int i = 0; i < 8; i++)
      if (m[3'(s + i)]) return 3'(s + i);
    return ad;
  endfunction
  function automatic logic [11:0] cw(input logic [2:0] ad, input logic [1:0] t,
      input logic [1:0] sq);
    return {rnd[11:8], ad, t, sq[0], sq[1], rnd[0]};
  endfunction
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // one conversion, then its routing
  task automatic conv(input logic [2:0] c, input logic [1:0] t);
    acs_host_model_inst.pulse();
    for (k = 0; k < 200 && done !== 1'b1; k++) @(posedge i_sys_clk) #2;
    chk("done", 12'h1, {11'h0, done});
    chk("busy", 12'h0, {11'h0, busy});
    @(posedge i_sys_clk) #2;
    chk("channel", {9'h0, c}, {9'h0, ch});
    chk("pos", {9'h0, c}, {9'h0, pos});
    chk("type", {10'h0, t}, {10'h0, o_type});
    chk("neg", {8'h0, exp_neg(t, c)}, {8'h0, gnd, neg});
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge i_sys_clk);
    #1 i_rstn = 1'b1;
    chk("reset", 12'h0, ctl_q);
    chk("reset gnd", 12'h1, {11'h0, gnd});
    for (j = 0; j < 12; j++)
    begin
      rnd = lfsr(rnd);
      ty = 2'(j);
      a = (ty == 2'h3 && rnd[14:12] == 3'h7) ? 3'h6 : rnd[14:12];
      ctl = cw(a, ty, acs_pkg::SQ_NONE);
      acs_host_model_inst.write(ctl);
      chk("control", ctl, ctl_q);
      conv(a, ty);
    end
    $display("direct test done");
    // shadow sets: single, pairs, common negative, empty
    for (j = 0; j < 5; j++)
    begin
      rnd = lfsr(rnd);
      ty = j == 1 ? 2'h1 : j == 2 ? 2'h3 : j == 3 ? 2'h2 : 2'h0;
      en = j == 0 ? 8'h29 : j == 1 ? 8'h3c : j == 3 ? 8'hcc : 8'h00;
      if (j == 2) en = rnd[7:0] & 8'h7f;
      a = rnd[18:16] & 3'h6;
      ctl = cw(a, ty, acs_pkg::SQ_SHADOW_SELECT_BIT);
      acs_host_model_inst.write(ctl);
      acs_host_model_inst.write({rnd[31:28], en});
      chk("control", ctl, ctl_q);
      for (int n = 0; n < 6; n++)
      begin
        if (n == 3 && j < 4)
        begin
          ctl = cw((ty == 2'h3 && rnd[22:20] == 3'h7) ? 3'h6 : rnd[22:20], ty, acs_pkg::SQ_KEEP);
          acs_host_model_inst.write(ctl);
          chk("control", ctl, ctl_q);
        end
        cur = exp_next(en, cur, n == 0, ty == 2'h1 || ty == 2'h2, a);
        conv(cur, ty);
      end
    end
    acs_host_model_inst.write(cw(3'h3, 2'h0, acs_pkg::SQ_CONSEC));
    for (j = 0; j < 6; j++) conv(3'(j % 4), 2'h0);
    acs_host_model_inst.write(cw(3'h5, 2'h0, acs_pkg::SQ_NONE));
    conv(3'h5, 2'h0);
    $display("sequence test done");
    // restart inside thirteen periods aborts
    acs_host_model_inst.pulse();
    repeat (12) @(posedge i_sys_clk);
    acs_host_model_inst.pulse();
    for (k = 0; k < 4 && abrt !== 1'b1; k++) @(posedge i_sys_clk) #2;
    chk("abort", 12'h1, {11'h0, abrt});
    chk("busy", 12'h1, {11'h0, busy});
    repeat (80) @(posedge i_sys_clk);
    $display("abort test done");
    results();
  end
  // watchdog well past the expected run
  initial
  begin
    #2000000;
    fails++;
    $display("MISMATCH watchdog expected end seen hang");
    results();
  end
endmodule // tb
